/* design/sfr_device.sv */
// Serial frame port: edge counting, data out, ready and error lines
//
// Contract
// - Sample data in on selected falling edges
// - Data out changes only on falling edges
// - Data out floats unless both selects low
// - Release data out after fourteenth falling edge
// - Ready goes low on sixteenth edge
// - Ready returns high on select rise
// - Controller raises select after sixteenth edge
// - First fall after select is bit one
// - Error pulls low on any fault
// - Error released after error register read
// - Ready chains to next select input
// - Daisy-chained serial clock at most 10MHz
// - Serial clock toggles only while selected
module sfr_device (
  // Clock and reset
  input  wire logic                         clk_sys_in,
  input  wire logic                         rst_in,
  // Serial link
  sfr_link_if.dev                           link,
  // Fault sources from the analog side
  input  wire logic [sfr_pkg::FAULT_W-1:0]  fault_in,
  // Received frames and status
  output logic      [sfr_pkg::FRAME_W-1:0]  rx_word_out,
  output logic                              rx_valid_out,
  output logic                              frame_abort_out,
  output logic      [sfr_pkg::FAULT_W-1:0]  err_flags_out
);
  import sfr_pkg::*;

  // Frame whose command field asks for the error register
  function automatic logic is_err_read(input logic [FRAME_W-1:0] word);
    return word[FRAME_W-1 -: CMD_W] == CMD_ERR_READ;
  endfunction

  // Two-stage synchronisers for every pin and fault input
  // Pin to action takes three clocks; the half period must exceed it
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] pins_raw;
  logic              sclk_prev;

  assign pins_raw = {fault_in, link.sclk, link.select_low_a,
                     link.select_low_b, link.mosi};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
          // Idle levels: pins high, faults clear
          sync1[gi] <= (gi < SY_FLT);
          sync2[gi] <= (gi < SY_FLT);
        end else begin
          sync1[gi] <= pins_raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  logic               sclk_s;
  logic               din_s;
  logic               selected;
  logic               sclk_fall;
  logic [FAULT_W-1:0] fault_s;

  assign sclk_s    = sync2[SY_SCLK];
  assign din_s     = sync2[SY_MOSI];
  assign fault_s   = sync2[SY_FLT +: FAULT_W];
  assign selected  = ~sync2[SY_SELA] & ~sync2[SY_SELB];
  // Fall seen on the synchronised clock
  assign sclk_fall = sclk_prev & ~sclk_s;

  // Frame state
  logic [CNT_W-1:0]   cnt;
  logic [FRAME_W-1:0] rx;
  logic [FRAME_W-1:0] tx;
  logic               miso_oe;
  logic               ready_n;
  logic               sel_prev;
  logic [FAULT_W-1:0] err;
  logic               err_oe;
  logic               done;

  logic [CNT_W-1:0]   next_cnt;
  logic [FRAME_W-1:0] next_rx;
  logic [FRAME_W-1:0] next_tx;
  logic               next_miso_oe;
  logic               next_ready_n;
  logic [FAULT_W-1:0] next_err;
  logic               next_err_oe;
  logic               next_done;
  logic [FRAME_W-1:0] next_rx_word;
  logic               next_rx_valid;
  logic               next_abort;
  logic [CNT_W-1:0]   cnt_inc;

  // Next state of the frame, one pass per clock
  always_comb begin
    cnt_inc       = CNT_W'(cnt + 1'b1);
    next_cnt      = cnt;
    next_rx       = rx;
    next_tx       = tx;
    next_miso_oe  = miso_oe;
    next_ready_n  = ready_n;
    next_done     = done;
    next_rx_word  = rx_word_out;
    next_rx_valid = 1'b0;
    next_abort    = 1'b0;
    next_err      = err | fault_s;
    if (!selected) begin
      next_cnt     = '0;
      next_done    = 1'b0;
      next_miso_oe = 1'b0;
      // Preload the reply with the latched fault flags
      next_tx      = {err, TX_PAD};
      next_ready_n = 1'b1;
      // Cut frame: selects rose before the sixteenth edge
      if (sel_prev && !done && cnt != '0) begin
        next_abort = 1'b1;
      end
    end else begin
      // Drive the reply from the first selected cycle
      if (!sel_prev) begin
        next_miso_oe = 1'b1;
      end
      if (sclk_fall && cnt < READY_EDGE) begin
        next_cnt = cnt_inc;
        next_rx  = {rx[FRAME_W-2:0], din_s};
        next_tx  = {tx[FRAME_W-2:0], 1'b0};
        if (cnt_inc == DOUT_STOP_EDGE) begin
          next_miso_oe = 1'b0;
        end
        if (cnt_inc == READY_EDGE) begin
          next_ready_n  = 1'b0;
          next_done     = 1'b1;
          next_rx_word  = next_rx;
          next_rx_valid = 1'b1;
          if (is_err_read(next_rx)) begin
            // Set wins: a fault still present stays latched
            next_err = fault_s;
          end
        end
      end
    end
    next_err_oe = |next_err;
  end

  // Every status output and every pin but the constant err_drv comes from a flop here
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_prev       <= 1'b1;
      sel_prev        <= 1'b0;
      cnt             <= '0;
      rx              <= '0;
      tx              <= '0;
      miso_oe         <= 1'b0;
      ready_n         <= 1'b1;
      done            <= 1'b0;
      err             <= '0;
      err_oe          <= 1'b0;
      rx_word_out     <= '0;
      rx_valid_out    <= 1'b0;
      frame_abort_out <= 1'b0;
      err_flags_out   <= '0;
    end else begin
      sclk_prev       <= sclk_s;
      sel_prev        <= selected;
      cnt             <= next_cnt;
      rx              <= next_rx;
      tx              <= next_tx;
      miso_oe         <= next_miso_oe;
      ready_n         <= next_ready_n;
      done            <= next_done;
      err             <= next_err;
      err_oe          <= next_err_oe;
      rx_word_out     <= next_rx_word;
      rx_valid_out    <= next_rx_valid;
      frame_abort_out <= next_abort;
      err_flags_out   <= next_err;
    end
  end

  // Pin drivers, all straight from flip-flops except err_drv, tied low
  assign link.miso_drv = tx[FRAME_W-1];
  assign link.miso_oe  = miso_oe;
  assign link.ready_n  = ready_n;
  // Open drain: only ever pulls the error line low
  assign link.err_drv  = 1'b0;
  assign link.err_oe   = err_oe;

endmodule

/* design/sfr_host.sv */
// Controller end: drives frames and watches ready and error lines
module sfr_host (
  // Clock and reset
  input  wire logic                         clk_sys_in,
  input  wire logic                         rst_in,
  // Serial link
  sfr_link_if.host                          link,
  // Frame request
  input  wire logic                         start_in,
  input  wire logic [sfr_pkg::FRAME_W-1:0]  tx_word_in,
  // Frame result and line status
  output logic                              busy_out,
  output logic                              done_out,
  output logic      [sfr_pkg::FRAME_W-1:0]  rx_word_out,
  output logic                              ready_seen_out,
  output logic                              error_seen_out
);
  import sfr_pkg::*;

  logic [HSYNC_W-1:0] hs1;
  logic [HSYNC_W-1:0] hs2;
  logic [HSYNC_W-1:0] hraw;

  assign hraw = {link.error_line_n, link.ready_n, link.miso_line};

  genvar gi;
  generate
    for (gi = 0; gi < HSYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
          hs1[gi] <= 1'b1;
          hs2[gi] <= 1'b1;
        end else begin
          hs1[gi] <= hraw[gi];
          hs2[gi] <= hs1[gi];
        end
      end
    end
  endgenerate

  sfr_host_state_e    state;
  logic [TMR_W-1:0]   tmr;
  logic [CNT_W-1:0]   edges;
  logic [FRAME_W-1:0] tx;
  logic [FRAME_W-1:0] rx;
  logic               sclk;
  logic               sel_n;

  sfr_host_state_e    next_state;
  logic [TMR_W-1:0]   next_tmr;
  logic [CNT_W-1:0]   next_edges;
  logic [FRAME_W-1:0] next_tx;
  logic [FRAME_W-1:0] next_rx;
  logic               next_sclk;
  logic               next_sel_n;
  logic               next_busy;
  logic               next_done;
  logic [FRAME_W-1:0] next_rx_word;
  logic               half_up;

  assign half_up = (tmr == HALF_LAST);

  always_comb begin
    next_state   = state;
    next_tmr     = TMR_W'(tmr + 1'b1);
    next_edges   = edges;
    next_tx      = tx;
    next_rx      = rx;
    next_sclk    = sclk;
    next_sel_n   = sel_n;
    next_busy    = busy_out;
    next_done    = 1'b0;
    next_rx_word = rx_word_out;
    unique case (state)
      SFR_IDLE: begin
        next_tmr  = '0;
        next_sclk = 1'b1;
        if (start_in) begin
          next_tx    = tx_word_in;
          next_rx    = '0;
          next_edges = '0;
          next_sel_n = 1'b0;
          next_busy  = 1'b1;
          next_state = SFR_SETUP;
        end
      end
      SFR_SETUP, SFR_HIGH: begin
        if (half_up) begin
          next_tmr = '0;
          if (edges == READY_EDGE) begin
            next_sel_n   = 1'b1;
            next_rx_word = rx;
            next_done    = 1'b1;
            next_state   = SFR_GAP;
          end else begin
            // Sample the reply just before each falling edge
            next_sclk  = 1'b0;
            next_rx    = {rx[FRAME_W-2:0], hs2[HY_MISO]};
            next_edges = CNT_W'(edges + 1'b1);
            next_state = SFR_LOW;
          end
        end
      end
      SFR_LOW: begin
        if (half_up) begin
          next_tmr   = '0;
          next_sclk  = 1'b1;
          next_tx    = {tx[FRAME_W-2:0], 1'b0};
          next_state = SFR_HIGH;
        end
      end
      SFR_GAP: begin
        if (half_up) begin
          next_busy  = 1'b0;
          next_state = SFR_IDLE;
        end
      end
      default: begin
        next_sel_n = 1'b1;
        next_sclk  = 1'b1;
        next_busy  = 1'b0;
        next_state = SFR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state          <= SFR_IDLE;
      tmr            <= '0;
      edges          <= '0;
      tx             <= '0;
      rx             <= '0;
      sclk           <= 1'b1;
      sel_n          <= 1'b1;
      busy_out       <= 1'b0;
      done_out       <= 1'b0;
      rx_word_out    <= '0;
      ready_seen_out <= 1'b0;
      error_seen_out <= 1'b0;
    end else begin
      state          <= next_state;
      tmr            <= next_tmr;
      edges          <= next_edges;
      tx             <= next_tx;
      rx             <= next_rx;
      sclk           <= next_sclk;
      sel_n          <= next_sel_n;
      busy_out       <= next_busy;
      done_out       <= next_done;
      rx_word_out    <= next_rx_word;
      ready_seen_out <= ~hs2[HY_READY];
      error_seen_out <= ~hs2[HY_ERR];
    end
  end

  assign link.sclk         = sclk;
  assign link.select_low_a = sel_n;
  assign link.select_low_b = sel_n;
  assign link.mosi         = tx[FRAME_W-1];

endmodule

/* pkg/sfr_link_if.sv */
// Serial link between the controller and the frame port
interface sfr_link_if;
  logic sclk;
  logic select_low_a;
  logic select_low_b;
  logic mosi;
  logic miso_drv;
  logic miso_oe;
  logic ready_n;
  logic err_drv;
  logic err_oe;
  // Resolved wire levels; undriven lines rest high through pull-ups
  logic miso_line;
  logic error_line_n;
  assign miso_line    = miso_oe ? miso_drv : 1'b1;
  assign error_line_n = err_oe ? err_drv : 1'b1;
  // Frame port end
  modport dev (
    input  sclk, select_low_a, select_low_b, mosi,
    output miso_drv, miso_oe, ready_n, err_drv, err_oe
  );
  // Controller end; in a chain ready_n feeds the next select instead
  modport host (
    output sclk, select_low_a, select_low_b, mosi,
    input  miso_line, ready_n, error_line_n
  );
endinterface

/* pkg/sfr_pkg.sv */
// Shared constants for the serial frame port and its controller
package sfr_pkg;
  // Frame shape, counted in serial clock falling edges
  localparam int unsigned FRAME_W       = 16;
  localparam int unsigned CNT_W         = 5;
  localparam logic [4:0]  DOUT_STOP_EDGE = 5'h0e;
  localparam logic [4:0]  FRAME_END_EDGE = 5'h0f;
  localparam logic [4:0]  READY_EDGE     = 5'h10;
  // Command field at the head of a frame
  localparam int unsigned CMD_W        = 2;
  localparam logic [1:0]  CMD_ERR_READ = 2'h3;
  // Fault sources: short, open, overtemperature, brownout
  localparam int unsigned FAULT_W     = 4;
  localparam int unsigned FLT_SHORT   = 0;
  localparam int unsigned FLT_OPEN    = 1;
  localparam int unsigned FLT_HOT     = 2;
  localparam int unsigned FLT_BROWN   = 3;
  localparam logic [11:0] TX_PAD      = 12'h000;
  // Positions in the device's synchroniser vector
  localparam int unsigned SY_MOSI  = 0;
  localparam int unsigned SY_SELB  = 1;
  localparam int unsigned SY_SELA  = 2;
  localparam int unsigned SY_SCLK  = 3;
  localparam int unsigned SY_FLT   = 4;
  localparam int unsigned SYNC_W   = FAULT_W + 4;
  // Positions in the controller's synchroniser vector
  localparam int unsigned HY_MISO  = 0;
  localparam int unsigned HY_READY = 1;
  localparam int unsigned HY_ERR   = 2;
  localparam int unsigned HSYNC_W  = 3;
  // Timing: system clock and the daisy-chain clock ceiling
  localparam int unsigned CLK_PERIOD_NS     = 40;
  localparam int unsigned SCLK_DAISY_MAX_KHZ = 10000;
  localparam int unsigned SCLK_MIN_PERIOD_NS = 1000000 / SCLK_DAISY_MAX_KHZ;
  localparam int unsigned SCLK_MIN_HALF_CYC  =
    (SCLK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  // Half period also leaves room for both ends' two-stage synchronisers
  localparam int unsigned SCLK_CDC_HALF_CYC = 8;
  localparam int unsigned SCLK_HALF_CYC     =
    (SCLK_CDC_HALF_CYC > SCLK_MIN_HALF_CYC) ? SCLK_CDC_HALF_CYC : SCLK_MIN_HALF_CYC;
  localparam int unsigned TMR_W = 4;
  localparam logic [3:0]  HALF_LAST = 4'(SCLK_HALF_CYC - 1);
  // Controller states
  typedef enum logic [2:0] {
    SFR_IDLE  = 3'b000,
    SFR_SETUP = 3'b001,
    SFR_LOW   = 3'b010,
    SFR_HIGH  = 3'b011,
    SFR_GAP   = 3'b100
  } sfr_host_state_e;
endpackage

/* testbench/sfr_link_properties.sv */
// Link checker for the serial frame port and its controller
module sfr_link_properties
  import sfr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Link signals
  input wire logic sclk,
  input wire logic select_low_a,
  input wire logic select_low_b,
  input wire logic mosi,
  input wire logic miso_drv,
  input wire logic miso_oe,
  input wire logic ready_n,
  input wire logic err_drv,
  input wire logic err_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       sclk_q;
  logic [4:0] fall_cnt;
  logic [1:0] cmd;
  logic [4:0] next_fall_cnt;
  logic [1:0] next_cmd;

  // Pin-level falling edge count within a frame
  always_comb begin
    next_fall_cnt = fall_cnt;
    next_cmd      = cmd;
    if (select_low_a || select_low_b) begin
      next_fall_cnt = 5'h00;
    end else if (sclk_q && !sclk && (fall_cnt < READY_EDGE)) begin
      next_fall_cnt = fall_cnt + 5'h01;
      if (fall_cnt < 5'h02) begin
        next_cmd = {cmd[0], mosi};
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_q   <= 1'b1;
      fall_cnt <= 5'h00;
      cmd      <= 2'h0;
    end else begin
      sclk_q   <= sclk;
      fall_cnt <= next_fall_cnt;
      cmd      <= next_cmd;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence s_sel_low;
    !select_low_a && !select_low_b;
  endsequence
  sequence s_sel_high;
    select_low_a || select_low_b;
  endsequence

  property p_oe_off_deselect;
    s_sel_high [*5] |-> !miso_oe;
  endproperty
  property p_oe_on_select;
    (!select_low_a && !select_low_b && (fall_cnt < DOUT_STOP_EDGE)) [*6] |-> miso_oe;
  endproperty
  property p_drv_on_fall;
    miso_oe && $past(miso_oe, 2) && $changed(miso_drv) |-> !sclk;
  endproperty
  property p_oe_off_after_14;
    (fall_cnt >= DOUT_STOP_EDGE) [*5] |-> !miso_oe;
  endproperty
  property p_ready_on_16;
    $rose(fall_cnt == READY_EDGE) |-> ##[1:4] !ready_n;
  endproperty
  property p_ready_cause;
    $fell(ready_n) |-> (fall_cnt == READY_EDGE);
  endproperty
  property p_ready_hold;
    (!ready_n && !select_low_a && !select_low_b) ##1 s_sel_low |-> !ready_n;
  endproperty
  property p_ready_rise;
    $rose(select_low_a) && !ready_n |-> ##[1:5] ready_n;
  endproperty
  property p_err_pull;
    err_oe |-> !err_drv ##1 (err_oe || (fall_cnt == READY_EDGE));
  endproperty
  property p_err_release;
    $fell(err_oe) |-> (cmd == CMD_ERR_READ) && (fall_cnt == READY_EDGE);
  endproperty

  a_oe_off_deselect:
    assert property (p_oe_off_deselect) else $error("data out driven while deselected");
  a_oe_on_select:
    assert property (p_oe_on_select) else $error("data out not driven while selected");
  a_drv_on_fall:
    assert property (p_drv_on_fall) else $error("data out changed with clock high");
  a_oe_off_after_14:
    assert property (p_oe_off_after_14) else $error("data out driven after edge 14");
  a_ready_on_16:
    assert property (p_ready_on_16) else $error("ready late after edge 16");
  a_ready_cause:
    assert property (p_ready_cause) else $error("ready fell before edge 16");
  a_ready_hold:
    assert property (p_ready_hold) else $error("ready rose while selected");
  a_ready_rise:
    assert property (p_ready_rise) else $error("ready stuck after select rise");
  a_err_pull:
    assert property (p_err_pull) else $error("error line released before read");
  a_err_release:
    assert property (p_err_release) else $error("error released without read");
endmodule

/* testbench/spi_frame_ready_error_port_tb.sv */
// Self-checking bench joining the frame port and its controller
module spi_frame_ready_error_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sfr_pkg::*;

  typedef struct {
    logic [3:0]  flt;
    logic [15:0] tx;
    logic [15:0] hrx;
    logic [3:0]  flg;
  } sfr_row_s;

  logic        clk_sys_in = 1'b0;
  logic        rst_in;
  logic [3:0]  fault_in;
  logic        start_in;
  logic [15:0] tx_word_in;
  logic [15:0] dev_rx_word;
  logic        dev_rx_valid;
  logic        dev_abort;
  logic [3:0]  dev_flags;
  logic        busy;
  logic        done;
  logic [15:0] host_rx_word;
  logic        ready_seen;
  logic        error_seen;
  integer      num_errors = 0;
  integer      compares   = 0;
  integer      valid_cnt  = 0;
  integer      abort_cnt  = 0;
  integer      v0;
  sfr_row_s    rows [7];

  sfr_link_if link ();

  sfr_device u_sfr_device (
    .clk_sys_in      (clk_sys_in),
    .rst_in          (rst_in),
    .link            (link),
    .fault_in        (fault_in),
    .rx_word_out     (dev_rx_word),
    .rx_valid_out    (dev_rx_valid),
    .frame_abort_out (dev_abort),
    .err_flags_out   (dev_flags)
  );

  sfr_host u_sfr_host (
    .clk_sys_in     (clk_sys_in),
    .rst_in         (rst_in),
    .link           (link),
    .start_in       (start_in),
    .tx_word_in     (tx_word_in),
    .busy_out       (busy),
    .done_out       (done),
    .rx_word_out    (host_rx_word),
    .ready_seen_out (ready_seen),
    .error_seen_out (error_seen)
  );

  sfr_link_properties u_sfr_link_properties (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .sclk         (link.sclk),
    .select_low_a (link.select_low_a),
    .select_low_b (link.select_low_b),
    .mosi         (link.mosi),
    .miso_drv     (link.miso_drv),
    .miso_oe      (link.miso_oe),
    .ready_n      (link.ready_n),
    .err_drv      (link.err_drv),
    .err_oe       (link.err_oe)
  );

  always #20 clk_sys_in = ~clk_sys_in;

  always @(posedge clk_sys_in) begin
    if (dev_rx_valid === 1'b1) valid_cnt <= valid_cnt + 1;
    if (dev_abort === 1'b1) abort_cnt <= abort_cnt + 1;
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge clk_sys_in);
    #2;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    if (n >= 400) check("done", 16'h1, 16'h0);
  endtask

  task automatic run_frame(input logic [15:0] tx);
    tx_word_in = tx;
    start_in   = 1'b1;
    tick();
    start_in = 1'b0;
    wait_done();
  endtask

  task automatic print_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #240000;
    num_errors++;
    print_verdict();
  end

  initial begin
    rst_in     = 1'b1;
    fault_in   = 4'h0;
    start_in   = 1'b0;
    tx_word_in = 16'h0000;
    rows = '{'{4'h0, 16'h1234, 16'h0003, 4'h0}, '{4'h5, 16'h4abc, 16'h5003, 4'h5},
             '{4'h0, 16'hc000, 16'h5003, 4'h0}, '{4'ha, 16'h8001, 16'ha003, 4'ha},
             '{4'h0, 16'hffff, 16'ha003, 4'h0}, '{4'h8, 16'hc0f0, 16'h8003, 4'h8},
             '{4'h0, 16'hc5a5, 16'h8003, 4'h0}};
    repeat (6) tick();
    check("rst_oe", 16'h0, 16'(link.miso_oe));
    check("rst_ready", 16'h1, 16'(link.ready_n));
    check("rst_err", 16'h1, 16'(link.error_line_n));
    check("rst_sel", 16'h1, 16'(link.select_low_a));
    repeat (6) tick();
    rst_in = 1'b0;
    repeat (2) tick();
    foreach (rows[i]) begin
      fault_in = rows[i].flt;
      repeat (4) tick();
      v0 = valid_cnt;
      run_frame(rows[i].tx);
      check("dev_rx", rows[i].tx, dev_rx_word);
      check("host_rx", rows[i].hrx, host_rx_word);
      check("ready_low", 16'h0, 16'(link.ready_n));
      check("ready_seen", 16'h1, 16'(ready_seen));
      check("valid_cnt", 16'(v0 + 1), 16'(valid_cnt));
      repeat (10) tick();
      check("ready_high", 16'h1, 16'(link.ready_n));
      check("ready_gone", 16'h0, 16'(ready_seen));
      check("oe_idle", 16'h0, 16'(link.miso_oe));
      check("flags", 16'(rows[i].flg), 16'(dev_flags));
      check("err_line", 16'(rows[i].flg == 4'h0), 16'(link.error_line_n));
      check("err_seen", 16'(rows[i].flg != 4'h0), 16'(error_seen));
    end
    // Back-to-back frames, word change while busy is ignored
    tx_word_in = 16'h0ff0;
    start_in   = 1'b1;
    tick();
    tx_word_in = 16'hf00f;
    wait_done();
    check("b2b_first", 16'h0ff0, dev_rx_word);
    while (busy === 1'b1) tick();
    tick();
    start_in = 1'b0;
    tick();
    check("b2b_busy", 16'h1, 16'(busy));
    wait_done();
    check("b2b_second", 16'hf00f, dev_rx_word);
    repeat (10) tick();
    // Reset in mid-frame, then a clean frame
    tx_word_in = 16'h3c3c;
    start_in   = 1'b1;
    tick();
    start_in = 1'b0;
    repeat (100) tick();
    rst_in = 1'b1;
    repeat (2) tick();
    check("mid_oe", 16'h0, 16'(link.miso_oe));
    check("mid_ready", 16'h1, 16'(link.ready_n));
    rst_in = 1'b0;
    repeat (2) tick();
    run_frame(16'h2961);
    check("after_rst_rx", 16'h2961, dev_rx_word);
    check("aborts", 16'h0, 16'(abort_cnt));
    repeat (10) tick();
    print_verdict();
  end
endmodule
